// ==== rtl/mts_defines.svh ====
`ifndef MTS_DEFINES_SVH
`define MTS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CMD      8'h00
`define REG_FUNC     8'h04
`define REG_RANGE    8'h08
`define REG_RESOL    8'h0C
`define REG_TRIG     8'h10
`define REG_SAMP     8'h14
`define REG_TCNT     8'h18
`define REG_STATUS   8'h1C
`define REG_MATH     8'h20
`define REG_BW       8'h24
`define REG_AZ       8'h28
`define REG_MCNT     8'h2C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMD_OP_F     3:0
`define CMD_FUNC_F   7:4
`define FUNC_F       3:0
`define RNG_KIND_F   1:0
`define RNG_IDX_F    7:4
`define RNG_INTEGRATION_LINE_CYCLES_F   10:8
`define RESOL_F      15:0
`define TRIG_SRC_F   1:0
`define TRIG_AUTO_B  2
`define TRIG_DLY_F   31:16
`define CNT_F        15:0
`define BW_F         1:0

// ----------------------------------------------------------------
// sizes and codes
// ----------------------------------------------------------------
`define READING_W    32
`define MEM_AW       9
`define CNT_W        10
`define MEM_LIMIT    32'h0000_0200
`define BW_20HZ      2'h1
`define INTEGRATION_LINE_CYCLES_ONE     3'h2
`define RANGE_LO     4'h0
`define RANGE_HI     4'h7
`define RANGE_FREQ   4'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_INTEGRATION_LINE_CYCLES     3'h3
`define RST_CNT      16'h0001
`define RST_BW       2'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_CLK_MHZ    25
`define CYC_PER_US     (`SYS_CLK_MHZ)
`define AUTO_DELAY_NS  1000
`define AUTO_DELAY_CYC ((`AUTO_DELAY_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/mts_pkg.sv ====
package mts_pkg;

  typedef enum logic [7:0] {
    S_IDLE    = 8'h01,
    S_WAIT    = 8'h02,
    S_DELAY   = 8'h04,
    S_MEAS_GO = 8'h08,
    S_MEAS_WT = 8'h10,
    S_SEND    = 8'h20,
    S_RD      = 8'h40,
    S_LD      = 8'h80
  } state_e;

  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_PRESET     = 4'h1,
    CMD_PRESET_MEAS = 4'h2,
    CMD_ARM_OUT    = 4'h3,
    CMD_ARM_MEM    = 4'h4,
    CMD_FETCH      = 4'h5,
    CMD_BUS_TRIG   = 4'h6,
    CMD_CLEAR      = 4'h7
  } cmd_e;

  typedef enum logic [3:0] {
    FN_DCV = 4'h0, FN_RATIO = 4'h1, FN_ACV = 4'h2, FN_DCI = 4'h3,
    FN_ACI = 4'h4, FN_RES2 = 4'h5, FN_RES4 = 4'h6, FN_FREQ = 4'h7,
    FN_PER = 4'h8, FN_CONT = 4'h9, FN_DIODE = 4'hA
  } func_e;

  typedef enum logic [1:0] {
    SRC_IMM = 2'h0,
    SRC_BUS = 2'h1,
    SRC_EXT = 2'h2
  } src_e;

  typedef enum logic [1:0] {
    RK_VALUE = 2'h0,
    RK_MIN   = 2'h1,
    RK_MAX   = 2'h2,
    RK_DEF   = 2'h3
  } rkind_e;

endpackage

// ==== rtl/reading_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mts_defines.svh"

module reading_mem (
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [`MEM_AW-1:0]      wr_addr,
  input  wire logic [`READING_W-1:0]   wr_data,
  input  wire logic                    rd_en,
  input  wire logic [`MEM_AW-1:0]      rd_addr,
  output logic      [`READING_W-1:0]   rd_data
);

  logic [`READING_W-1:0] mem [0:(1<<`MEM_AW)-1];

  // no reset: contents are only meaningful below the write count
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ==== rtl/measurement_trigger_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mts_defines.svh"

module measurement_trigger_sequencer (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  ext_trig_in,
  output logic                       meas_start,
  input  wire logic                  meas_done,
  input  wire logic [`READING_W-1:0] meas_data,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic      [`READING_W-1:0] out_data,
  output mts_pkg::func_e             meas_func,
  output logic      [3:0]            range_idx,
  output logic                       autorange_en,
  output logic      [2:0]            integration_line_cycles,
  output logic                       autozero_en,
  output logic      [1:0]            ac_filter_bandwidth,
  output logic                       math_function_subsystem
);
  import mts_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic is_freq(input func_e f);
    is_freq = (f == FN_FREQ) || (f == FN_PER);
  endfunction

  state_e      state_q;
  state_e      state_d;
  func_e       func_q;
  src_e        trigger_source_select;
  logic [3:0]  range_q;
  logic        auto_q;
  logic [2:0]  integration_line_cycles_q;
  logic [15:0] resol_q;
  logic        trigger_delay_setting;
  logic [15:0] dly_us_q;
  logic [15:0] samples_per_trigger;
  logic [15:0] trigger_repeat_count;
  logic        math_q;
  logic [1:0]  bw_q;
  logic        az_q;
  logic [15:0] samp_left_q;
  logic [15:0] trig_left_q;
  logic        to_mem_q;
  logic        fetching_q;
  logic [31:0] dly_cnt_q;
  logic [`CNT_W-1:0] wr_ptr_q;
  logic [`CNT_W-1:0] rd_ptr_q;
  logic        ext_d_q;
  logic        mem_err_q;
  logic        rej_q;
  logic [`READING_W-1:0] out_q;
  logic [`READING_W-1:0] mem_rdata;
  logic [31:0] rdata_q;

  cmd_e  op;
  func_e cmd_func;
  logic  wr_cmd;
  logic  busy;
  logic  bus_trig;
  logic  do_clear;
  logic  do_preset;
  logic  arm_out;
  logic  arm_mem_req;
  logic  mem_over;
  logic  arm_mem;
  logic  do_fetch;
  logic  cfg_wr;
  logic  rejected;
  logic  fire;
  logic  after_rdg;
  logic  last_samp;
  logic  mem_wr;
  logic  stat_rd;

  assign op       = cmd_e'(reg_wdata[`CMD_OP_F]);
  assign cmd_func = func_e'(reg_wdata[`CMD_FUNC_F]);
  assign wr_cmd   = reg_wr && (reg_addr == `REG_CMD);
  assign busy     = (state_q != S_IDLE);
  assign do_clear = wr_cmd && (op == CMD_CLEAR);
  // bus trigger still gets through while a sequence runs
  assign bus_trig = wr_cmd && (op == CMD_BUS_TRIG) &&
                    (trigger_source_select == SRC_BUS);
  assign do_preset = wr_cmd && !busy &&
                     ((op == CMD_PRESET) || (op == CMD_PRESET_MEAS));
  // preset-and-preset_and_query_a arms the output path in the same cycle
  assign arm_out  = wr_cmd && !busy &&
                    ((op == CMD_ARM_OUT) || (op == CMD_PRESET_MEAS));
  assign arm_mem_req = wr_cmd && !busy && (op == CMD_ARM_MEM);
  assign mem_over = (32'(samples_per_trigger) * 32'(trigger_repeat_count))
                    > `MEM_LIMIT;
  assign arm_mem  = arm_mem_req && !mem_over;
  assign do_fetch = wr_cmd && !busy && (op == CMD_FETCH) &&
                    (wr_ptr_q != '0);
  assign cfg_wr   = reg_wr && !busy;
  // any other write while busy is dropped and flagged
  assign rejected = reg_wr && busy && !do_clear && !bus_trig;
  assign stat_rd  = reg_rd && (reg_addr == `REG_STATUS);

  // ----------------------------------------------------------------
  // trigger and sequence control
  // ----------------------------------------------------------------
  always_comb begin
    case (trigger_source_select)
      SRC_EXT: fire = ext_trig_in && !ext_d_q;
      SRC_BUS: fire = bus_trig;
      default: fire = 1'b1;
    endcase
  end

  assign last_samp = (samp_left_q <= 16'h0001);
  assign mem_wr    = (state_q == S_MEAS_WT) && meas_done && to_mem_q;
  // a held output stalls the sequence until the buffer drains
  assign after_rdg = mem_wr || ((state_q == S_SEND) && out_ready &&
                     !fetching_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (arm_out || arm_mem) begin
          state_d = S_WAIT;
        end else if (do_fetch) begin
          state_d = S_RD;
        end
      end
      S_WAIT: begin
        if (fire) begin
          state_d = S_DELAY;
        end
      end
      S_DELAY: begin
        if (dly_cnt_q == 32'h0000_0000) begin
          state_d = S_MEAS_GO;
        end
      end
      S_MEAS_GO: state_d = S_MEAS_WT;
      S_MEAS_WT: begin
        if (meas_done && !to_mem_q) begin
          state_d = S_SEND;
        end
      end
      S_SEND: begin
        if (out_ready && fetching_q) begin
          state_d = (rd_ptr_q + 1'b1 == wr_ptr_q) ? S_IDLE : S_RD;
        end
      end
      S_RD: state_d = S_LD;
      S_LD: state_d = S_SEND;
      default: state_d = S_IDLE;
    endcase
    if (after_rdg) begin
      if (!last_samp) begin
        state_d = S_MEAS_GO;
      end else if (trig_left_q <= 16'h0001) begin
        state_d = S_IDLE;
      end else begin
        state_d = S_WAIT;
      end
    end
    if (do_clear) begin
      state_d = S_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_d_q <= 1'b0;
    end else begin
      ext_d_q <= ext_trig_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dly_cnt_q <= 32'h0000_0000;
    end else if (state_q == S_WAIT) begin
      dly_cnt_q <= trigger_delay_setting ? 32'(`AUTO_DELAY_CYC) :
                   32'(dly_us_q) * 32'(`CYC_PER_US);
    end else if (dly_cnt_q != 32'h0000_0000) begin
      dly_cnt_q <= dly_cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      samp_left_q <= `RST_CNT;
      trig_left_q <= `RST_CNT;
      to_mem_q    <= 1'b0;
      fetching_q  <= 1'b0;
    end else if (arm_out || arm_mem) begin
      // preset-and-preset_and_query_a arms on the preset edge: use the preset counts
      samp_left_q <= do_preset ? `RST_CNT : samples_per_trigger;
      trig_left_q <= do_preset ? `RST_CNT : trigger_repeat_count;
      to_mem_q    <= arm_mem;
      fetching_q  <= 1'b0;
    end else if (do_fetch) begin
      fetching_q  <= 1'b1;
    end else if (after_rdg) begin
      if (!last_samp) begin
        samp_left_q <= samp_left_q - 16'h0001;
      end else begin
        samp_left_q <= samples_per_trigger;
        trig_left_q <= trig_left_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // reading memory and output buffer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_ptr_q <= '0;
    end else if (arm_mem) begin
      wr_ptr_q <= '0;
    end else if (mem_wr) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_ptr_q <= '0;
    end else if (do_fetch) begin
      rd_ptr_q <= '0;
    end else if ((state_q == S_SEND) && out_ready && fetching_q) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // stored readings stay until the next arm-to-memory overwrites them
  reading_mem u_mem (
    .clk     (sys_clk),
    .wr_en   (mem_wr),
    .wr_addr (wr_ptr_q[`MEM_AW-1:0]),
    .wr_data (meas_data),
    .rd_en   (state_q == S_RD),
    .rd_addr (rd_ptr_q[`MEM_AW-1:0]),
    .rd_data (mem_rdata)
  );

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_q <= '0;
    end else if ((state_q == S_MEAS_WT) && meas_done && !to_mem_q) begin
      out_q <= meas_data;
    end else if (state_q == S_LD) begin
      out_q <= mem_rdata;
    end
  end

  assign out_valid  = (state_q == S_SEND);
  assign out_data   = out_q;
  assign meas_start = (state_q == S_MEAS_GO);

  // ----------------------------------------------------------------
  // measurement configuration
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      func_q  <= FN_DCV;
      range_q <= `RANGE_LO;
      auto_q  <= 1'b1;
      integration_line_cycles_q  <= `RST_INTEGRATION_LINE_CYCLES;
      resol_q <= '0;
    end else if (do_preset) begin
      func_q <= cmd_func;
      if (is_freq(cmd_func)) begin
        range_q <= `RANGE_FREQ;
        auto_q  <= 1'b0;
      end
    end else if (cfg_wr && (reg_addr == `REG_FUNC)) begin
      func_q <= func_e'(reg_wdata[`FUNC_F]);
      if (is_freq(func_e'(reg_wdata[`FUNC_F]))) begin
        range_q <= `RANGE_FREQ;
        auto_q  <= 1'b0;
      end
    end else if (cfg_wr && (reg_addr == `REG_RANGE)) begin
      // range and integration line cycles arrive together in one write
      integration_line_cycles_q <= reg_wdata[`RNG_INTEGRATION_LINE_CYCLES_F];
      if (is_freq(func_q)) begin
        range_q <= `RANGE_FREQ;
        auto_q  <= 1'b0;
      end else begin
        case (rkind_e'(reg_wdata[`RNG_KIND_F]))
          RK_MIN: begin
            range_q <= `RANGE_LO;
            auto_q  <= 1'b0;
          end
          RK_MAX: begin
            range_q <= `RANGE_HI;
            auto_q  <= 1'b0;
          end
          RK_DEF: auto_q <= 1'b1;
          default: begin
            range_q <= reg_wdata[`RNG_IDX_F];
            auto_q  <= 1'b0;
          end
        endcase
      end
    end else if (cfg_wr && (reg_addr == `REG_RESOL)) begin
      resol_q <= reg_wdata[`RESOL_F];
    end
  end

  // preset wins over a plain write; later writes refine it
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trigger_source_select <= SRC_IMM;
      trigger_delay_setting <= 1'b1;
      dly_us_q              <= '0;
      samples_per_trigger   <= `RST_CNT;
      trigger_repeat_count  <= `RST_CNT;
      math_q                <= 1'b0;
      bw_q                  <= `RST_BW;
      az_q                  <= 1'b1;
    end else if (do_preset) begin
      bw_q                  <= `BW_20HZ;
      az_q                  <= (integration_line_cycles_q >= `INTEGRATION_LINE_CYCLES_ONE);
      samples_per_trigger   <= `RST_CNT;
      trigger_repeat_count  <= `RST_CNT;
      trigger_delay_setting <= 1'b1;
      trigger_source_select <= SRC_IMM;
      math_q                <= 1'b0;
    end else if (cfg_wr) begin
      case (reg_addr)
        `REG_TRIG: begin
          trigger_source_select <= src_e'(reg_wdata[`TRIG_SRC_F]);
          trigger_delay_setting <= reg_wdata[`TRIG_AUTO_B];
          dly_us_q              <= reg_wdata[`TRIG_DLY_F];
        end
        `REG_SAMP: samples_per_trigger  <= reg_wdata[`CNT_F];
        `REG_TCNT: trigger_repeat_count <= reg_wdata[`CNT_F];
        `REG_MATH: math_q <= reg_wdata[0];
        `REG_BW:   bw_q   <= reg_wdata[`BW_F];
        `REG_AZ:   az_q   <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  assign meas_func               = func_q;
  assign range_idx               = range_q;
  assign autorange_en            = auto_q;
  assign integration_line_cycles = integration_line_cycles_q;
  assign autozero_en             = az_q;
  assign ac_filter_bandwidth     = bw_q;
  assign math_function_subsystem = math_q;

  // ----------------------------------------------------------------
  // status and read port
  // ----------------------------------------------------------------
  // status read clears the sticky flags; a new event in that cycle wins
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_err_q <= 1'b0;
      rej_q     <= 1'b0;
    end else begin
      if (arm_mem_req && mem_over) begin
        mem_err_q <= 1'b1;
      end else if (stat_rd) begin
        mem_err_q <= 1'b0;
      end
      if (rejected) begin
        rej_q <= 1'b1;
      end else if (stat_rd) begin
        rej_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_FUNC:   rdata_q <= {28'h0, func_q};
        `REG_RANGE:  rdata_q <= {21'h0, integration_line_cycles_q, range_q, 2'h0, auto_q, 1'b0};
        `REG_RESOL:  rdata_q <= {16'h0, resol_q};
        `REG_TRIG:   rdata_q <= {dly_us_q, 13'h0, trigger_delay_setting,
                                 trigger_source_select};
        `REG_SAMP:   rdata_q <= {16'h0, samples_per_trigger};
        `REG_TCNT:   rdata_q <= {16'h0, trigger_repeat_count};
        `REG_STATUS: rdata_q <= {20'h0, state_q, to_mem_q, busy,
                                 rej_q, mem_err_q};
        `REG_MATH:   rdata_q <= {31'h0, math_q};
        `REG_BW:     rdata_q <= {30'h0, bw_q};
        `REG_AZ:     rdata_q <= {31'h0, az_q};
        `REG_MCNT:   rdata_q <= {22'h0, wr_ptr_q};
        default:     rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ==== bench/meas_engine_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module meas_engine_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        meas_start,
  input  wire logic        slow,
  input  wire logic [31:0] base,
  output logic             meas_done,
  output logic      [31:0] meas_data
);
  logic [3:0]  wait_q;
  logic        busy_q;
  logic [31:0] cnt_q;
  // data toggles outside done so a stale reading can never match
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q    <= 1'b0;
      wait_q    <= 4'h0;
      cnt_q     <= 32'h0;
      meas_done <= 1'b0;
      meas_data <= 32'h0;
    end else begin
      meas_done <= 1'b0;
      meas_data <= ~meas_data;
      if (meas_start) begin
        busy_q <= 1'b1;
        wait_q <= slow ? 4'h7 : 4'h0;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q    <= 1'b0;
        meas_done <= 1'b1;
        meas_data <= base + cnt_q * 32'h0101_0101;
        cnt_q     <= cnt_q + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/mts_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module mts_properties
  import mts_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        meas_start,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [31:0] out_data,
  input wire func_e       meas_func,
  input wire logic [3:0]  range_idx,
  input wire logic        autorange_en,
  input wire logic [2:0]  integration_line_cycles,
  input wire logic        autozero_en,
  input wire logic [1:0]  ac_filter_bandwidth,
  input wire logic        math_function_subsystem
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // checks assume config writes only while idle; the bench writes only the sample count while busy
  logic cmd_w;
  logic pre_w;
  logic fp;
  assign cmd_w = reg_wr && reg_addr == 8'h00;
  assign pre_w = cmd_w && reg_wdata[3:0] inside {4'h1, 4'h2};
  assign fp    = meas_func == FN_FREQ || meas_func == FN_PER;
  AST_PRESET_BW: assert property (pre_w |=> ac_filter_bandwidth == 2'h1
    && !math_function_subsystem) else $error("preset state wrong");
  AST_PRESET_AZ: assert property (pre_w |=>
    autozero_en == (integration_line_cycles >= 3'h2)) else $error("az wrong");
  AST_MEAS_NOW: assert property (cmd_w && reg_wdata[3:0] == 4'h2
    |-> ##[2:40] meas_start) else $error("no measurement");
  AST_ARM_WAIT: assert property (cmd_w && reg_wdata[3:0] == 4'h3
    |=> !meas_start [*8]) else $error("start before trigger");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("output dropped");
  AST_PAUSE: assert property (out_valid && !out_ready |=>
    !meas_start) else $error("measured while output full");
  AST_FREQ_RANGE: assert property (fp && $stable(meas_func) |->
    range_idx == 4'h0 && !autorange_en) else $error("freq range");
  AST_RANGE_MAX: assert property (reg_wr && reg_addr == 8'h08 && !fp
    && reg_wdata[1:0] == 2'h2 |=> range_idx == 4'h7) else $error("max");
  AST_FUNC_SEL: assert property (reg_wr && reg_addr == 8'h04 |=>
    meas_func == $past(reg_wdata[3:0])) else $error("function select");
endmodule
bind measurement_trigger_sequencer mts_properties chk (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .meas_start(meas_start),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
  .meas_func(meas_func), .range_idx(range_idx),
  .autorange_en(autorange_en), .autozero_en(autozero_en),
  .integration_line_cycles(integration_line_cycles),
  .ac_filter_bandwidth(ac_filter_bandwidth),
  .math_function_subsystem(math_function_subsystem));
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import mts_pkg::*;
  logic        sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic        ext_trig_in = 0, out_ready = 0, slow = 0, stall = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, base = 32'h0, st, reg_rdata, out_data;
  logic [31:0] meas_data;
  logic        meas_start, meas_done, out_valid, autorange_en, autozero_en;
  logic        math_function_subsystem;
  logic [3:0]  range_idx;
  logic [2:0]  integration_line_cycles;
  logic [1:0]  ac_filter_bandwidth;
  func_e       meas_func;
  int          errors = 0, samples_checked = 0, nrx = 0, ms_cnt = 0;
  int          n0, m0, i, f;
  measurement_trigger_sequencer DUT (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig_in(ext_trig_in),
    .meas_start(meas_start), .meas_done(meas_done), .meas_data(meas_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .meas_func(meas_func), .range_idx(range_idx),
    .autorange_en(autorange_en), .autozero_en(autozero_en),
    .integration_line_cycles(integration_line_cycles),
    .ac_filter_bandwidth(ac_filter_bandwidth),
    .math_function_subsystem(math_function_subsystem));
  meas_engine_model eng (.clk(sys_clk), .resetn(resetn), .slow(slow),
    .meas_start(meas_start), .base(base), .meas_done(meas_done),
    .meas_data(meas_data));
  function automatic logic [31:0] exp_rd(int n);
    return base + 32'(n) * 32'h0101_0101;
  endfunction
  always #20 sys_clk = ~sys_clk;
  // random back-pressure on the output buffer
  always @(posedge sys_clk) begin
    if (meas_start === 1'b1) ms_cnt++;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      `CHK(out_data, exp_rd(nrx))
      nrx++;
    end
    out_ready <= stall ? 1'b0 : 1'($urandom % 2);
  end
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask
  task automatic idle();
    for (int k = 0; k < 200 && !(k > 0 && st[2] === 1'b0); k++) rd(8'h1C);
    `CHK(st[11:4], 8'h01)
  endtask
  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h88012467));
    base = $urandom;
    cyc(6);
    resetn <= 1'b1;
    cyc(4);
    for (i = 0; i < 6; i++) begin
      f = (i == 0) ? 7 : $urandom % 11;
      wr(8'h04, 32'(f));
      cyc(1);
      `CHK(meas_func, func_e'(f))
      if (f == 7 || f == 8) `CHK({range_idx, autorange_en}, 5'h00)
    end
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h2);
    cyc(1);
    `CHK(range_idx, 4'h7)
    wr(8'h08, 32'h1);
    cyc(1);
    `CHK(range_idx, 4'h0)
    wr(8'h08, 32'h103);
    cyc(1);
    `CHK(autorange_en, 1'b1)
    f = $urandom;
    wr(8'h0C, 32'(f));
    rd(8'h0C);
    `CHK(st, {16'h0, 16'(f)})
    wr(8'h24, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h18, 32'h3);
    n0 = nrx;
    wr(8'h00, 32'h2);
    cyc(1);
    `CHK({ac_filter_bandwidth, math_function_subsystem, autozero_en}, 4'h4)
    idle();
    `CHK(nrx, n0 + 1)
    wr(8'h08, 32'h303);
    wr(8'h00, 32'h1);
    m0 = ms_cnt;
    cyc(60);
    `CHK({autozero_en, 32'(ms_cnt)}, {1'b1, 32'(m0)})
    `CHK(integration_line_cycles, 3'h3)
    wr(8'h14, 32'h3);
    stall <= 1'b1;
    n0 = nrx;
    wr(8'h00, 32'h3);
    cyc(120);
    `CHK({out_valid, 32'(ms_cnt)}, {1'b1, 32'(m0 + 1)})
    stall <= 1'b0;
    idle();
    `CHK(nrx, n0 + 3)
    rd(8'h2C);
    `CHK(st[9:0], 10'h000)
    slow <= 1'b1;
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h2);
    wr(8'h10, 32'h5);
    n0 = nrx;
    wr(8'h00, 32'h4);
    wr(8'h14, 32'h1);
    rd(8'h1C);
    `CHK(st[2:1], 2'h3)
    repeat (2) begin
      wr(8'h00, 32'h6);
      cyc(100);
    end
    `CHK(nrx, n0)
    idle();
    rd(8'h2C);
    `CHK(st[9:0], 10'h004)
    wr(8'h00, 32'h5);
    idle();
    `CHK(nrx, n0 + 4)
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h201);
    wr(8'h00, 32'h4);
    rd(8'h1C);
    `CHK(st[2:0], 3'h1)
    slow <= 1'b0;
    wr(8'h10, 32'h6);
    wr(8'h14, 32'h1);
    m0 = ms_cnt;
    n0 = nrx;
    wr(8'h00, 32'h3);
    cyc(60);
    `CHK(ms_cnt, m0)
    ext_trig_in <= 1'b1;
    cyc(2);
    ext_trig_in <= 1'b0;
    idle();
    `CHK(nrx, n0 + 1)
    complete_run();
  end
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
